// File: hdl/pwmoc_params.svh
// Constants for the two-channel pulse-width output block
//
// Overview of operation
// R1: Per-mil format takes duty 0..1000; pulse = duty/1000 of period; default format.
// R2: Analog format takes duty 0..27648; pulse = duty/27648 of period.
// R3: Time base 1ms, 0.1ms or 1us, default 0.1ms, scales period, minimum, delay.
// R4: After start, wait the on-delay before the first pulse reaches the output.
// R5: On-delay accepts 0..65535 time-base units, default 0.
// R6: Period is pulse plus pause; default 20000 time-base units.
// R7: With 0.1ms base the period starts at 0.4 ms; others at one unit.
// R8: Pulses or pauses shorter than the minimum pulse duration are suppressed; default 2.
// R9: Minimum limited to half the period; lower bound 2 at 0.1ms, else 0.
// R10: Pulse-width modulation exists on output channels 0 and 1 only.
// R11: Pulse-width and pulse-train modes share hardware; the control block selects mode.
// R12: Program uses only the control block; process words from address 816 are reserved.
// R13: Output active for pulse duration, inactive for the rest, repeated while running.
`ifndef PWMOC_PARAMS_SVH
`define PWMOC_PARAMS_SVH
`define PWMOC_CLK_HZ 50000000
`define PWMOC_TB_1MS_NS 1000000
`define PWMOC_TB_100US_NS 100000
`define PWMOC_TB_1US_NS 1000
`define PWMOC_TICKS(ns) (((ns) * 64'd50) / 64'd1000)
`define PWMOC_PERMIL_MAX 17'h0_03E8
`define PWMOC_ANALOG_MAX 17'h0_6C00
`define PWMOC_DEF_PERIOD 16'h4E20
`define PWMOC_DEF_MINPULSE 16'h0002
`define PWMOC_DEF_DELAY 16'h0000
`define PWMOC_MIN_PERIOD_100US 16'h0004
`define PWMOC_MIN_PERIOD_OTHER 16'h0001
`define PWMOC_MIN_PULSE_100US 16'h0002
`define PWMOC_CHANNELS 2
`endif

// File: hdl/pwmoc_pkg.sv
// Types for the two-channel pulse-width output block
package pwmoc_pkg;
   typedef enum logic [1:0] {
      PWMOC_TB_1MS = 2'b00,
      PWMOC_TB_100US = 2'b01,
      PWMOC_TB_1US = 2'b10
   } pwmoc_tbase_t;
   typedef enum logic {
      PWMOC_FMT_PERMIL = 1'b0,
      PWMOC_FMT_ANALOG = 1'b1
   } pwmoc_fmt_t;
   typedef enum logic {
      PWMOC_MODE_PWM = 1'b0,
      PWMOC_MODE_TRAIN = 1'b1
   } pwmoc_mode_t;
   typedef struct packed {
      pwmoc_fmt_t fmt;
      pwmoc_tbase_t tbase;
      logic [15:0] on_delay;
      logic [15:0] period;
      logic [15:0] min_pulse;
   } pwmoc_cfg_t;
   typedef enum logic [1:0] {
      PWMOC_ST_IDLE = 2'b00,
      PWMOC_ST_DELAY = 2'b01,
      PWMOC_ST_RUN = 2'b10
   } pwmoc_state_t;
endpackage

// File: hdl/pwmoc_output_channel.sv
// Two-channel pulse-width modulated output generator
`timescale 1ns/1ps
`include "pwmoc_params.svh"
module pwmoc_output_channel
   import pwmoc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire pwmoc_cfg_t i_cfg,
   input wire pwmoc_mode_t i_mode,
   input wire logic [1:0] i_run,
   input wire logic [31:0] i_duty,
   output logic [1:0] o_pwm,
   output logic [1:0] o_active,
   output logic [1:0] o_duty_err
);
   localparam logic [16:0] TICK_1MS = 17'(`PWMOC_TICKS(`PWMOC_TB_1MS_NS));
   localparam logic [16:0] TICK_100US = 17'(`PWMOC_TICKS(`PWMOC_TB_100US_NS));
   localparam logic [16:0] TICK_1US = 17'(`PWMOC_TICKS(`PWMOC_TB_1US_NS));

   // Time-base prescaler shared by both channels
   logic [16:0] pre_cnt;
   wire logic [16:0] tick_len = (i_cfg.tbase == PWMOC_TB_1MS) ? TICK_1MS :
      (i_cfg.tbase == PWMOC_TB_1US) ? TICK_1US : TICK_100US; // [R3]
   wire logic tick = (pre_cnt >= tick_len - 17'h0_0001);
   always_ff @(posedge i_clk) begin
      if (i_rst || tick)
         pre_cnt <= 17'h0_0000;
      else
         pre_cnt <= pre_cnt + 17'h0_0001;
   end

   // Period and minimum limits for the selected base
   wire logic is_100us = (i_cfg.tbase == PWMOC_TB_100US);
   wire logic [15:0] per_floor = is_100us ? `PWMOC_MIN_PERIOD_100US
      : `PWMOC_MIN_PERIOD_OTHER; // [R7]
   wire logic [15:0] per_eff = (i_cfg.period < per_floor) ? per_floor : i_cfg.period; // [R6] [R7]
   wire logic [15:0] min_floor = is_100us ? `PWMOC_MIN_PULSE_100US : 16'h0000;
   wire logic [15:0] min_half = {1'b0, per_eff[15:1]};
   wire logic [15:0] min_lo = (i_cfg.min_pulse < min_floor) ? min_floor : i_cfg.min_pulse;
   wire logic [15:0] min_eff = (min_lo > min_half) ? min_half : min_lo; // [R9]
   wire logic [16:0] scale = (i_cfg.fmt == PWMOC_FMT_ANALOG) ? `PWMOC_ANALOG_MAX
      : `PWMOC_PERMIL_MAX; // [R1] [R2]

   // Next-state values, one per channel
   logic [1:0] next_pwm;
   logic [1:0] next_err;

   genvar ch;
   generate
      for (ch = 0; ch < `PWMOC_CHANNELS; ch++) begin : g_ch // [R10]
         pwmoc_state_t state;
         pwmoc_state_t next_state;
         logic [15:0] cnt;
         logic [15:0] pulse;
         wire logic [15:0] duty_in = i_duty[ch*16 +: 16];
         wire logic over = ({1'b0, duty_in} > scale);
         wire logic [16:0] duty_c = over ? scale : {1'b0, duty_in}; // [R1] [R2]
         wire logic [32:0] prod = 33'(duty_c) * 33'(per_eff);
         wire logic [15:0] raw_pulse = 16'(prod / 33'(scale)); // [R1] [R2]
         wire logic [15:0] pause = per_eff - raw_pulse;
         // Short pulse drops to zero, short pause stretches to full period
         wire logic [15:0] filt_pulse = (raw_pulse < min_eff) ? 16'h0000 :
            (pause < min_eff) ? per_eff : raw_pulse; // [R8]
         wire logic enable = i_run[ch] && (i_mode == PWMOC_MODE_PWM); // [R11]
         wire logic last = (cnt >= per_eff - 16'h0001);
         wire logic delay_done = (cnt >= i_cfg.on_delay); // [R5]

         always_comb begin
            next_state = state;
            unique case (state)
               PWMOC_ST_IDLE: begin
                  if (enable)
                     next_state = PWMOC_ST_DELAY;
               end
               PWMOC_ST_DELAY: begin
                  if (!enable)
                     next_state = PWMOC_ST_IDLE;
                  else if (delay_done)
                     next_state = PWMOC_ST_RUN; // [R4]
               end
               PWMOC_ST_RUN: begin
                  if (!enable)
                     next_state = PWMOC_ST_IDLE;
               end
               default: next_state = PWMOC_ST_IDLE;
            endcase
         end

         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               state <= PWMOC_ST_IDLE;
               cnt <= 16'h0000;
               pulse <= 16'h0000;
            end else begin
               state <= next_state;
               if (next_state != state)
                  cnt <= 16'h0000;
               else if (tick && state == PWMOC_ST_DELAY)
                  cnt <= cnt + 16'h0001;
               else if (tick && state == PWMOC_ST_RUN)
                  cnt <= last ? 16'h0000 : cnt + 16'h0001; // [R13]
               // New duty takes effect at the start of each period
               if (next_state == PWMOC_ST_RUN && (state != PWMOC_ST_RUN || (tick && last)))
                  pulse <= filt_pulse; // [R8] [R13]
            end
         end

         assign next_pwm[ch] = (state == PWMOC_ST_RUN) && (cnt < pulse); // [R13]
         assign next_err[ch] = over;
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pwm <= 2'b00;
         o_active <= 2'b00;
         o_duty_err <= 2'b00;
      end else begin
         o_pwm <= next_pwm;
         o_active <= {g_ch[1].state == PWMOC_ST_RUN, g_ch[0].state == PWMOC_ST_RUN};
         o_duty_err <= next_err;
      end
   end
endmodule // pwmoc_output_channel

// File: dv/pwmoc_output_channel_chk.sv
// Port checks for the pulse-width output block
`timescale 1ns/1ps
module pwmoc_output_channel_chk
   import pwmoc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire pwmoc_cfg_t i_cfg,
   input wire pwmoc_mode_t i_mode,
   input wire logic [1:0] i_run,
   input wire logic [1:0] o_pwm,
   input wire logic [1:0] o_active
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   reset_clear_a: assert property (disable iff (1'b0) i_rst |=> !(o_pwm | o_active))
      else $error("outputs not cleared by reset");
   stop_quiet_a: assert property (!i_run[0] [*2] |=> !o_pwm[0] && !o_active[0])
      else $error("stopped channel still drives");
   train_idle_a: assert property (i_mode [*2] |=> o_active == 2'b00)
      else $error("pulse train mode left a channel running");
   pwm_gated_a: assert property ((o_pwm & ~o_active) == 2'b00)
      else $error("output high outside run phase");
   delay_hold_a: assert property ($rose(i_run[0]) && !i_mode && i_cfg.on_delay > 16'h0001
      |-> ##1 !o_active[0] [*8]) else $error("on-delay skipped");
   chan_split_a: assert property (o_active[1] |-> $past(i_run[1], 2))
      else $error("channel 1 active without its run");
   run_keep_a: assert property ((i_run[0] && !i_mode) [*2] ##0 o_active[0] |=> o_active[0])
      else $error("running channel dropped out");
   fall_cause_a: assert property ($fell(o_active[1]) |-> !$past(i_run[1], 2) || $past(i_mode, 2))
      else $error("channel 1 stopped without cause");
endmodule // pwmoc_output_channel_chk
bind pwmoc_output_channel pwmoc_output_channel_chk i_chk (.*);

// File: dv/pwmoc_actuator.sv
// Actuator model that totals the clocks its drive pin is on
`timescale 1ns/1ps
module pwmoc_actuator (
   input wire logic i_clk,
   input wire logic i_clr,
   input wire logic i_drive,
   output logic [31:0] o_on_clks
);
   always_ff @(posedge i_clk) begin
      o_on_clks <= i_clr ? 32'h0 : o_on_clks + {31'h0, i_drive};
   end
endmodule // pwmoc_actuator

// File: dv/pwmoc_output_channel_test.sv
// Self-checking bench for the pulse-width output block
`timescale 1ns/1ps
module pwmoc_output_channel_test;
   import pwmoc_pkg::*;
   logic i_clk = 0, i_rst = 1, clr = 0;
   pwmoc_cfg_t i_cfg = '0;
   pwmoc_mode_t i_mode = PWMOC_MODE_PWM;
   logic [1:0] i_run = 0, o_pwm, o_active, o_duty_err;
   logic [31:0] i_duty = 0, hi0, hi1;
   int fail_count = 0, n_compared = 0, q[$], sc, tk, d1, w;
   int t[7][6] = '{'{0,2,300,10,0,3}, '{1,2,13824,10,0,2}, '{0,2,100,10,2,0},
      '{0,2,1500,10,2,0}, '{0,2,900,10,2,0}, '{1,2,30000,8,9,0}, '{0,1,250,4,0,0}};
   pwmoc_output_channel i_dut (.*);
   pwmoc_actuator i_act0 (.i_clk(i_clk), .i_clr(clr), .i_drive(o_pwm[0]), .o_on_clks(hi0));
   pwmoc_actuator i_act1 (.i_clk(i_clk), .i_clr(clr), .i_drive(o_pwm[1]), .o_on_clks(hi1));
   initial forever #10 i_clk = ~i_clk;
   function automatic int hi(int k, int d);
      int s, mn, h;
      s = t[k][0] ? 27648 : 1000;
      mn = t[k][4] < 2 && t[k][1] == 1 ? 2 : t[k][4];
      mn = mn > t[k][3] / 2 ? t[k][3] / 2 : mn;
      h = (d > s ? s : d) * t[k][3] / s;
      return h < mn ? 0 : t[k][3] - h < mn ? t[k][3] : h;
   endfunction
   task automatic check(input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH at %0t: saw %0d want %0d", $time, s, e);
      end
   endtask
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      fail_count++;
      give_verdict;
   end
   initial begin
      tk = $urandom(32'h0000_1806);
      repeat (16) @(negedge i_clk);
      i_rst = 0;
      foreach (t[k]) begin
         i_cfg = {1'(t[k][0]), 2'(t[k][1]), 16'(t[k][5]), 16'(t[k][3]), 16'(t[k][4])};
         sc = t[k][0] ? 27648 : 1000;
         tk = t[k][1] == 1 ? 5000 : 50;
         d1 = $urandom_range(sc);
         i_duty = {16'(d1), 16'(t[k][2])};
         q.push_back(hi(k, t[k][2]));
         q.push_back(hi(k, d1));
         i_run = 2'b11;
         for (w = 0; w < 9000 && o_active !== 2'b11; w++) @(negedge i_clk);
         repeat (t[k][3] * tk) @(negedge i_clk);
         clr = 1;
         @(negedge i_clk);
         clr = 0;
         repeat (2 * t[k][3] * tk) @(negedge i_clk);
         check(hi0, 2 * tk * q.pop_front());
         check(hi1, 2 * tk * q.pop_front());
         check(o_duty_err[0], t[k][2] > sc);
         check(o_duty_err[1], d1 > sc);
         i_mode = PWMOC_MODE_TRAIN;
         repeat (3) @(negedge i_clk);
         check(o_active, 0);
         i_mode = PWMOC_MODE_PWM;
         i_run = 0;
         repeat (3) @(negedge i_clk);
      end
      give_verdict;
   end
endmodule // pwmoc_output_channel_test
